// ---- hw/sfcd_defs.vh ----
// sfcd_defs.vh: opcodes, decode fields and fixed counts of the serial
// flash command decoder. definitions only, included by the decoder.
`ifndef SFCD_DEFS_VH
`define SFCD_DEFS_VH

// opcodes
`define SFCD_OP_WRITE_ENABLE_CMD_CMD   8'h06
`define SFCD_OP_WRITE_DISABLE_CMD_CMD   8'h04
`define SFCD_OP_STAT1_RD   8'h05
`define SFCD_OP_STAT2_RD   8'h35
`define SFCD_OP_STAT_WR    8'h01
`define SFCD_OP_READ       8'h03
`define SFCD_OP_FAST_READ  8'h0B
`define SFCD_OP_DUAL_OUT   8'h3B
`define SFCD_OP_DUAL_IO    8'hBB
`define SFCD_OP_OTP_RD_A   8'h4B
`define SFCD_OP_OTP_RD_B   8'h48
`define SFCD_OP_OTP_PROG   8'h42
`define SFCD_OP_PAGE_PROG  8'h02
`define SFCD_OP_TWO_PROG   8'hA2
`define SFCD_OP_CLEAR_4K   8'h20
`define SFCD_OP_BLK_ERA_A  8'hD8
`define SFCD_OP_BLK_ERA_B  8'h52
`define SFCD_OP_CHIP_ERA_A 8'hC7
`define SFCD_OP_CHIP_ERA_B 8'h60
`define SFCD_OP_DEEP_PD    8'hB9
`define SFCD_OP_JEDEC_ID   8'h9F
`define SFCD_OP_MAKER_DEV  8'h90
`define SFCD_OP_WAKE_SIG   8'hAB

// decode word: {known, byte-boundary class, needs latch, data in,
// data out, address bytes[1:0], dummy bytes[1:0]}
`define SFCD_DEC_KNOWN   8
`define SFCD_DEC_WCLASS  7
`define SFCD_DEC_NEEDWEL 6
`define SFCD_DEC_DIN     5
`define SFCD_DEC_DOUT    4
`define SFCD_DEC_NADDR   3:2
`define SFCD_DEC_NDUM    1:0
`define SFCD_DEC_NONE    9'h000
`define SFCD_DEC_CTRL    9'h1A0
`define SFCD_DEC_WR0     9'h1E0
`define SFCD_DEC_WR3     9'h1EC
`define SFCD_DEC_OUT0    9'h110
`define SFCD_DEC_RD3     9'h11C
`define SFCD_DEC_FRD3    9'h11D
`define SFCD_DEC_MAKER   9'h116
`define SFCD_DEC_WAKE    9'h113

// data byte limits
`define SFCD_MAX_PAGE    9'h100
`define SFCD_MAX_OTP     9'h040
`define SFCD_MAX_STAT    9'h002
`define SFCD_MAX_NONE    9'h000
`define SFCD_OTP_AMSB    5

// status and mode bits
`define SFCD_ST_WIP      0
`define SFCD_ST_WEL      1
`define SFCD_MODE_EXIT   4
`define SFCD_MODE_FLD    5:4
`define SFCD_MODE_CONT   2'h2
`define SFCD_MODE_RST    8'h00
`define SFCD_ONES_EXIT   5'h10

// pin reset levels {io1, io0, cs_n, sck}
`define SFCD_PIN_RST     4'h2

`endif

// ---- hw/sfcd_pin_sync.v ----
// sfcd_pin_sync: three-stage synchroniser with agreement filter.
// assumes pins are asynchronous to clock_i and slower than 3 cycles.
`timescale 1ns/100ps
module sfcd_pin_sync #(
  parameter       W       = 4,
  parameter [3:0] RST_VAL = 4'h0
) (
  // clock and reset
  input  wire         clock_i,
  input  wire         sys_rst_i,
  input  wire         clk_en_i,
  // pins
  input  wire [W-1:0] pin_i,
  // filtered level and edge pulses
  output reg  [W-1:0] lvl_o,
  output reg  [W-1:0] rise_o,
  output reg  [W-1:0] fall_o
);

  reg [W-1:0] ff1_r;
  reg [W-1:0] ff2_r;
  reg [W-1:0] ff3_r;

  // ff1 feeds ff2 only; the level moves once ff2 and ff3 agree
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ff1_r  <= RST_VAL[W-1:0];
      ff2_r  <= RST_VAL[W-1:0];
      ff3_r  <= RST_VAL[W-1:0];
      lvl_o  <= RST_VAL[W-1:0];
      rise_o <= {W{1'b0}};
      fall_o <= {W{1'b0}};
    end else if (clk_en_i) begin
      ff1_r  <= pin_i;
      ff2_r  <= ff1_r;
      ff3_r  <= ff2_r;
      lvl_o  <= (ff2_r & ~(ff2_r ^ ff3_r)) | (lvl_o & (ff2_r ^ ff3_r));
      rise_o <= ~(ff2_r ^ ff3_r) & ff3_r & ~lvl_o;
      fall_o <= ~(ff2_r ^ ff3_r) & ~ff3_r & lvl_o;
    end
  end

endmodule

// ---- hw/sfcd_decoder.v ----
// sfcd_decoder: opcode decoder and write enable latch of a serial flash.
// assumes clock_i at 50 MHz, serial clock at most an eighth of that, and
// an array controller that takes exec/write strobes and answers reads.
//
// How it works
// - opcode 06h sets write enable latch
// - opcode 04h clears write enable latch
// - program, erase, status write need latch set
// - latch cleared at reset and as the exec cycle is launched
// - 05h/35h return status byte one/two
// - status reads honoured even while busy
// - status byte repeats while clocks continue
// - 03h three address; 0Bh adds one dummy
// - 3Bh data out on two lines
// - BBh address and mode on two lines
// - otp read: three address, one dummy
// - otp program: three address, 1-64 bytes
// - page/two-line program: 1-256 bytes
// - 90h one address, two dummies; 9Fh streams
// - B9h powers down, ABh releases, signature
// - sixteen ones force mode bit four
// - msb first, sampled on rising clock
// - write class needs byte-aligned chip select
// - busy: only status reads and continuous frames accepted
`timescale 1ns/100ps
`include "sfcd_defs.vh"
module sfcd_decoder #(
  parameter [7:0] MAKER_ID  = 8'h5A, // arbitrary value
  parameter [7:0] DEVICE_ID = 8'h15, // arbitrary value
  parameter [7:0] JEDEC_TYP = 8'h30, // arbitrary value
  parameter [7:0] JEDEC_CAP = 8'h16, // arbitrary value
  parameter [7:0] SIGNATURE = 8'h15  // arbitrary value
) (
  // clock, reset, enable
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        clk_en_i,
  // serial link pins
  input  wire        spi_sck_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_io0_i,
  output reg         spi_io0_o,
  output reg         spi_io0_oe_n_o,
  input  wire        spi_io1_i,
  output reg         spi_io1_o,
  output reg         spi_io1_oe_n_o,
  // status from array side
  input  wire        write_in_progress_i,
  input  wire [7:0]  status1_i,
  input  wire [7:0]  status2_i,
  // latch and power state
  output reg         write_enable_latch_o,
  output reg         deep_power_down_o,
  // execute request to array
  output reg         exec_o,
  output reg  [7:0]  exec_opcode_o,
  output reg  [23:0] exec_addr_o,
  output reg  [8:0]  exec_len_o,
  // program data
  output reg         wr_strobe_o,
  output reg  [7:0]  wr_data_o,
  // array read
  output reg         rd_req_o,
  output reg         rd_otp_o,
  output reg  [23:0] rd_addr_o,
  input  wire [7:0]  rd_data_i
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_OPC   = 3'd1;
  localparam [2:0] ST_ADDR  = 3'd2;
  localparam [2:0] ST_DUMMY = 3'd3;
  localparam [2:0] ST_DIN   = 3'd4;
  localparam [2:0] ST_DOUT  = 3'd5;
  localparam [2:0] ST_IGN   = 3'd6;

  function [8:0] sfcd_decode;
    input [7:0] op;
    begin
      case (op)
        `SFCD_OP_WRITE_ENABLE_CMD_CMD,
        `SFCD_OP_WRITE_DISABLE_CMD_CMD,
        `SFCD_OP_DEEP_PD:    sfcd_decode = `SFCD_DEC_CTRL;
        `SFCD_OP_STAT_WR,
        `SFCD_OP_CHIP_ERA_A,
        `SFCD_OP_CHIP_ERA_B: sfcd_decode = `SFCD_DEC_WR0;
        `SFCD_OP_OTP_PROG,
        `SFCD_OP_PAGE_PROG,
        `SFCD_OP_TWO_PROG,
        `SFCD_OP_CLEAR_4K,
        `SFCD_OP_BLK_ERA_A,
        `SFCD_OP_BLK_ERA_B:  sfcd_decode = `SFCD_DEC_WR3;
        `SFCD_OP_STAT1_RD,
        `SFCD_OP_STAT2_RD,
        `SFCD_OP_JEDEC_ID:   sfcd_decode = `SFCD_DEC_OUT0;
        `SFCD_OP_READ:       sfcd_decode = `SFCD_DEC_RD3;
        `SFCD_OP_FAST_READ,
        `SFCD_OP_DUAL_OUT,
        `SFCD_OP_DUAL_IO,
        `SFCD_OP_OTP_RD_A,
        `SFCD_OP_OTP_RD_B:   sfcd_decode = `SFCD_DEC_FRD3;
        `SFCD_OP_MAKER_DEV:  sfcd_decode = `SFCD_DEC_MAKER;
        `SFCD_OP_WAKE_SIG:   sfcd_decode = `SFCD_DEC_WAKE;
        default:             sfcd_decode = `SFCD_DEC_NONE;
      endcase
    end
  endfunction

  function [8:0] sfcd_dmax;
    input [7:0] op;
    begin
      case (op)
        `SFCD_OP_PAGE_PROG,
        `SFCD_OP_TWO_PROG:   sfcd_dmax = `SFCD_MAX_PAGE;
        `SFCD_OP_OTP_PROG:   sfcd_dmax = `SFCD_MAX_OTP;
        `SFCD_OP_STAT_WR:    sfcd_dmax = `SFCD_MAX_STAT;
        default:             sfcd_dmax = `SFCD_MAX_NONE;
      endcase
    end
  endfunction

  // phase that follows the address bytes (or the opcode if none)
  function [2:0] sfcd_after;
    input [8:0] dec;
    begin
      if (dec[`SFCD_DEC_NDUM] != 2'd0)
        sfcd_after = ST_DUMMY;
      else if (dec[`SFCD_DEC_DIN])
        sfcd_after = ST_DIN;
      else
        sfcd_after = ST_DOUT;
    end
  endfunction

  wire [3:0] pin_lvl;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;

  sfcd_pin_sync #(
    .W       (4),
    .RST_VAL (`SFCD_PIN_RST)
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .pin_i     ({spi_io1_i, spi_io0_i, spi_cs_n_i, spi_sck_i}),
    .lvl_o     (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  wire sck_rise = pin_rise[0];
  wire sck_fall = pin_fall[0];
  wire cs_n_s   = pin_lvl[1];
  wire cs_fall  = pin_fall[1];
  wire cs_rise  = pin_rise[1];
  wire io0_s    = pin_lvl[2];
  wire io1_s    = pin_lvl[3];

  reg  [2:0]  st_r;
  reg  [7:0]  op_r;
  reg  [7:0]  in_sh_r;
  reg  [7:0]  out_sh_r;
  reg  [7:0]  mode_r;
  reg  [23:0] addr_r;
  reg  [2:0]  bitc_r;
  reg  [2:0]  ocnt_r;
  reg  [1:0]  cnt_r;
  reg  [1:0]  idx_r;
  reg  [8:0]  dcnt_r;
  reg  [4:0]  ones_r;
  reg         rej_r;
  reg         wel_r;
  reg         dpd_r;
  reg  [7:0]  out_byte;

  wire dual_in = ((op_r == `SFCD_OP_DUAL_IO) && ((st_r == ST_ADDR) || (st_r == ST_DUMMY))) ||
                 ((op_r == `SFCD_OP_TWO_PROG) && (st_r == ST_DIN));
  wire [7:0]  in_nxt   = dual_in ? {in_sh_r[5:0], io1_s, io0_s} : {in_sh_r[6:0], io0_s};
  wire [2:0]  bitc_nxt = bitc_r + (dual_in ? 3'd2 : 3'd1);
  wire        byte_done = (bitc_nxt == 3'd0);
  wire [23:0] addr_cat = {addr_r[15:0], in_nxt};
  wire [8:0]  dec_in   = sfcd_decode(in_nxt);
  wire [8:0]  dec_op   = sfcd_decode(op_r);
  wire [8:0]  dmax     = sfcd_dmax(op_r);
  wire [8:0]  dmin     = (dmax != `SFCD_MAX_NONE) ? 9'h001 : 9'h000;
  wire        out_dual = (op_r == `SFCD_OP_DUAL_OUT) || (op_r == `SFCD_OP_DUAL_IO);
  wire        is_otp   = (op_r == `SFCD_OP_OTP_RD_A) || (op_r == `SFCD_OP_OTP_RD_B);
  wire        is_mem   = is_otp || (op_r == `SFCD_OP_READ) || (op_r == `SFCD_OP_FAST_READ) || out_dual;
  wire        cont_on  = (mode_r[`SFCD_MODE_FLD] == `SFCD_MODE_CONT);
  wire        st_read  = (in_nxt == `SFCD_OP_STAT1_RD) || (in_nxt == `SFCD_OP_STAT2_RD);
  wire        refuse   = !dec_in[`SFCD_DEC_KNOWN] || (write_in_progress_i && !st_read) ||
                         (dpd_r && (in_nxt != `SFCD_OP_WAKE_SIG)) ||
                         (dec_in[`SFCD_DEC_NEEDWEL] && !wel_r);
  wire [7:0]  byte_v   = (ocnt_r == 3'd0) ? out_byte : out_sh_r;
  // otp area is 64 bytes, so its read address wraps inside it
  wire [23:0] rd_inc   = is_otp ? {rd_addr_o[23:`SFCD_OTP_AMSB+1], rd_addr_o[`SFCD_OTP_AMSB:0] + 6'h01}
                                : rd_addr_o + 24'h00_0001;

  always @* begin
    case (op_r)
      // status bytes, latch and busy live
      `SFCD_OP_STAT1_RD: begin
        out_byte = status1_i;
        out_byte[`SFCD_ST_WIP] = write_in_progress_i;
        out_byte[`SFCD_ST_WEL] = wel_r;
      end
      `SFCD_OP_STAT2_RD: out_byte = status2_i;
      `SFCD_OP_JEDEC_ID: out_byte = (idx_r == 2'd0) ? MAKER_ID :
                                    (idx_r == 2'd1) ? JEDEC_TYP : JEDEC_CAP;
      `SFCD_OP_MAKER_DEV: out_byte = (idx_r[0] ^ addr_r[0]) ? DEVICE_ID : MAKER_ID;
      `SFCD_OP_WAKE_SIG: out_byte = SIGNATURE;
      default:           out_byte = rd_data_i;
    endcase
  end

  always @* begin
    write_enable_latch_o = wel_r;
    deep_power_down_o    = dpd_r;
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r           <= ST_IDLE;
      op_r           <= 8'h00;
      in_sh_r        <= 8'h00;
      out_sh_r       <= 8'h00;
      mode_r         <= `SFCD_MODE_RST;
      addr_r         <= 24'h00_0000;
      bitc_r         <= 3'd0;
      ocnt_r         <= 3'd0;
      cnt_r          <= 2'd0;
      idx_r          <= 2'd0;
      dcnt_r         <= 9'h000;
      ones_r         <= 5'h00;
      rej_r          <= 1'b0;
      wel_r          <= 1'b0;
      dpd_r          <= 1'b0;
      spi_io0_o      <= 1'b0;
      spi_io1_o      <= 1'b0;
      spi_io0_oe_n_o <= 1'b1;
      spi_io1_oe_n_o <= 1'b1;
      exec_o         <= 1'b0;
      exec_opcode_o  <= 8'h00;
      exec_addr_o    <= 24'h00_0000;
      exec_len_o     <= 9'h000;
      wr_strobe_o    <= 1'b0;
      wr_data_o      <= 8'h00;
      rd_req_o       <= 1'b0;
      rd_otp_o       <= 1'b0;
      rd_addr_o      <= 24'h00_0000;
    end else if (clk_en_i) begin
      exec_o      <= 1'b0;
      wr_strobe_o <= 1'b0;
      rd_req_o    <= 1'b0;
      if (cs_rise) begin
        spi_io0_oe_n_o <= 1'b1;
        spi_io1_oe_n_o <= 1'b1;
        st_r           <= ST_IDLE;
        if (st_r == ST_DIN && !rej_r && bitc_r == 3'd0 && dcnt_r >= dmin) begin
          case (op_r)
            `SFCD_OP_WRITE_ENABLE_CMD_CMD: wel_r <= 1'b1;
            `SFCD_OP_WRITE_DISABLE_CMD_CMD: wel_r <= 1'b0;
            `SFCD_OP_DEEP_PD:  dpd_r <= 1'b1;
            default: begin
              exec_o        <= 1'b1;
              exec_opcode_o <= op_r;
              exec_addr_o   <= addr_r;
              exec_len_o    <= dcnt_r;
              // latch cleared as the cycle is launched
              wel_r         <= 1'b0;
            end
          endcase
        end
      end else if (cs_fall) begin
        bitc_r <= 3'd0;
        ocnt_r <= 3'd0;
        idx_r  <= 2'd0;
        dcnt_r <= 9'h000;
        ones_r <= 5'h00;
        rej_r  <= 1'b0;
        // continuous mode skips the opcode and starts at the address
        if (cont_on && !dpd_r) begin
          st_r  <= ST_ADDR;
          op_r  <= `SFCD_OP_DUAL_IO;
          cnt_r <= 2'd3;
        end else begin
          st_r  <= ST_OPC;
        end
      end else if (!cs_n_s && sck_rise) begin
        in_sh_r <= in_nxt;
        bitc_r  <= bitc_nxt;
        if (byte_done) begin
          case (st_r)
            ST_OPC: begin
              op_r <= in_nxt;
              if (refuse) begin
                st_r <= ST_IGN;
              end else begin
                if (in_nxt == `SFCD_OP_WAKE_SIG)
                  dpd_r <= 1'b0;
                // address and dummy counts per opcode
                if (dec_in[`SFCD_DEC_NADDR] != 2'd0) begin
                  st_r  <= ST_ADDR;
                  cnt_r <= dec_in[`SFCD_DEC_NADDR];
                end else begin
                  st_r  <= sfcd_after(dec_in);
                  cnt_r <= dec_in[`SFCD_DEC_NDUM];
                end
              end
            end
            ST_ADDR: begin
              addr_r <= addr_cat;
              if (cnt_r == 2'd1) begin
                st_r  <= sfcd_after(dec_op);
                cnt_r <= dec_op[`SFCD_DEC_NDUM];
                if (is_mem && dec_op[`SFCD_DEC_NDUM] == 2'd0) begin
                  rd_req_o  <= 1'b1;
                  rd_otp_o  <= is_otp;
                  rd_addr_o <= addr_cat;
                end
              end else begin
                cnt_r <= cnt_r - 2'd1;
              end
            end
            ST_DUMMY: begin
              // mode byte of dual io read
              if (op_r == `SFCD_OP_DUAL_IO)
                mode_r <= in_nxt;
              if (cnt_r == 2'd1) begin
                st_r <= ST_DOUT;
                if (is_mem) begin
                  rd_req_o  <= 1'b1;
                  rd_otp_o  <= is_otp;
                  rd_addr_o <= addr_r;
                end
              end else begin
                cnt_r <= cnt_r - 2'd1;
              end
            end
            ST_DIN: begin
              if (dcnt_r == dmax) begin
                rej_r <= 1'b1;
              end else begin
                dcnt_r      <= dcnt_r + 9'h001;
                wr_strobe_o <= 1'b1;
                wr_data_o   <= in_nxt;
              end
            end
            default: st_r <= st_r;
          endcase
        end
        // sixteen ones leave continuous mode
        // after the mode byte load, so the forced bit wins
        if (io0_s) begin
          if (ones_r != `SFCD_ONES_EXIT)
            ones_r <= ones_r + 5'h01;
          if (ones_r == `SFCD_ONES_EXIT - 5'h01)
            mode_r[`SFCD_MODE_EXIT] <= 1'b1;
        end else begin
          ones_r <= 5'h00;
        end
      end else if (!cs_n_s && sck_fall && st_r == ST_DOUT) begin
        // odd bit on io1, even on io0
        spi_io1_o      <= byte_v[7];
        spi_io0_o      <= byte_v[6];
        spi_io1_oe_n_o <= 1'b0;
        spi_io0_oe_n_o <= ~out_dual;
        out_sh_r       <= out_dual ? {byte_v[5:0], 2'b00} : {byte_v[6:0], 1'b0};
        ocnt_r         <= ocnt_r + (out_dual ? 3'd2 : 3'd1);
        if (ocnt_r == 3'd0) begin
          idx_r <= (op_r == `SFCD_OP_JEDEC_ID && idx_r == 2'd2) ? 2'd0 : idx_r + 2'd1;
          // fetch next byte one byte ahead of need
          if (is_mem) begin
            rd_req_o  <= 1'b1;
            rd_addr_o <= rd_inc;
          end
        end
      end
    end
  end

endmodule

// ---- dv/sfcd_decoder_props.sv ----
// sfcd_decoder_props: port-level checks of the serial flash decoder.
// assumes serial clock levels and deselect gaps of at least 4 clocks.
`timescale 1ns/100ps
module sfcd_decoder_props (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  // link pins
  input wire logic       spi_cs_n_i,
  input wire logic       spi_io0_oe_n_o,
  input wire logic       spi_io1_oe_n_o,
  // state and strobes
  input wire logic       write_enable_latch_o,
  input wire logic       deep_power_down_o,
  input wire logic       exec_o,
  input wire logic       wr_strobe_o,
  input wire logic       rd_req_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  AST_EXEC_LATCH:
    assert property (exec_o |-> $past(write_enable_latch_o) && !write_enable_latch_o)
    else $error("exec without a consumed latch");
  AST_EXEC_DESEL:
    assert property (exec_o |-> $past(spi_cs_n_i, 3) ##1 !exec_o)
    else $error("exec not a single pulse after deselect");
  AST_LATCH_SET:
    assert property ($rose(write_enable_latch_o) |-> !exec_o && $past(spi_cs_n_i, 3))
    else $error("latch set outside a deselect");
  AST_LATCH_DESEL:
    assert property ($changed(write_enable_latch_o) |-> $past(spi_cs_n_i, 3))
    else $error("latch moved while selected");
  AST_PD_ENTER:
    assert property ($rose(deep_power_down_o) |-> $past(spi_cs_n_i, 3))
    else $error("power-down entered while selected");
  AST_PD_LEAVE:
    assert property ($fell(deep_power_down_o) |-> !$past(spi_cs_n_i, 4))
    else $error("power-down left outside a frame");
  AST_OE0_DUAL:
    assert property (!spi_io0_oe_n_o |-> !spi_io1_oe_n_o)
    else $error("io0 driven outside dual output");
  AST_OE_SEL:
    assert property (!spi_io1_oe_n_o |-> !$past(spi_cs_n_i, 5))
    else $error("io1 driven after deselect");
  AST_OE_IDLE:
    assert property (spi_cs_n_i [*6] |-> spi_io0_oe_n_o && spi_io1_oe_n_o)
    else $error("pins driven while idle");
  AST_WR_PULSE:
    assert property (wr_strobe_o |=> !wr_strobe_o)
    else $error("write strobe longer than one cycle");
  AST_RD_PULSE:
    assert property (rd_req_o |=> !rd_req_o)
    else $error("read request longer than one cycle");
endmodule

// ---- dv/sfcd_host_model.sv ----
// sfcd_host_model: behavioural serial link host, mode 0, 160 ns clock.
// assumes the bench calls its tasks; released lines toggle every bit.
`timescale 1ns/100ps
module sfcd_host_model (
  // clock
  input  wire logic clock_i,
  // wire levels
  input  wire logic io0_i,
  input  wire logic io1_i,
  // pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      io0_o,
  output logic      io1_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io0_o = 1'b0;
    io1_o = 1'b1;
  end
  // msb first, rising edge
  // sampled late in the high phase: the device answers 4-5 clocks after a fall
  task automatic pulse(input logic d1, d0, e1, e0, output logic q1, q0);
    @(posedge clock_i);
    io1_o <= e1 ? d1 : ~io1_o;
    io0_o <= e0 ? d0 : ~io0_o;
    repeat (3) @(posedge clock_i);
    sck_o <= 1'b1;
    repeat (3) @(posedge clock_i);
    q1 = io1_i;
    q0 = io0_i;
    @(posedge clock_i);
    sck_o <= 1'b0;
  endtask
  task automatic sel();
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic desel();
    @(posedge clock_i);
    cs_n_o <= 1'b1;
    io0_o <= ~io0_o;
    repeat (8) @(posedge clock_i);
  endtask
endmodule

// ---- dv/tb_top.sv ----
// tb_top: self-checking bench of the serial flash command decoder.
// assumes sfcd_host_model as link host and a behavioural array beside it.
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVID = 8'h71; // arbitrary value
  localparam logic [7:0] JTYP  = 8'h42; // arbitrary value
  localparam logic [7:0] JCAP  = 8'h17; // arbitrary value
  localparam logic [7:0] SIGN  = 8'h2E; // arbitrary value
  logic        clock_i, sys_rst_i, clk_en_i, busy, q1, q0;
  logic [7:0]  st1, st2, rd_data, wr_last, scr;
  wire         sck, cs_n, h_io0, h_io1, io0, io1, d_io0, d_oe0_n, d_io1, d_oe1_n;
  wire         write_enable_latch, pd, exec, wr_stb, rd_req, rd_otp;
  wire  [7:0]  ex_op, wr_data;
  wire  [23:0] ex_addr, rd_addr;
  wire  [8:0]  ex_len;
  int          bad_count, check_count, seed, n_exec, n_wr, drv_seen, drv0;
  logic [7:0]  ops [9] = '{8'h20, 8'hD8, 8'h52, 8'hC7, 8'h60, 8'h01, 8'h42, 8'hA2, 8'h02};
  assign io0 = !d_oe0_n ? d_io0 : h_io0;
  assign io1 = !d_oe1_n ? d_io1 : h_io1;

  sfcd_host_model u_host (.clock_i(clock_i), .io0_i(io0), .io1_i(io1), .sck_o(sck), .cs_n_o(cs_n),
    .io0_o(h_io0), .io1_o(h_io1));
  sfcd_decoder #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID), .JEDEC_TYP(JTYP), .JEDEC_CAP(JCAP),
    .SIGNATURE(SIGN)) u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_io0_i(io0), .spi_io0_o(d_io0), .spi_io0_oe_n_o(d_oe0_n),
    .spi_io1_i(io1), .spi_io1_o(d_io1), .spi_io1_oe_n_o(d_oe1_n), .write_in_progress_i(busy),
    .status1_i(st1), .status2_i(st2), .write_enable_latch_o(write_enable_latch), .deep_power_down_o(pd),
    .exec_o(exec), .exec_opcode_o(ex_op), .exec_addr_o(ex_addr), .exec_len_o(ex_len),
    .wr_strobe_o(wr_stb), .wr_data_o(wr_data), .rd_req_o(rd_req), .rd_otp_o(rd_otp),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  function automatic logic [7:0] memf(input logic [23:0] a, input logic o);
    return a[7:0] ^ a[15:8] ^ {7'h00, o} ^ 8'h5A;
  endfunction

  // array side: answers each read request well inside the 4-clock window
  always @(posedge clock_i) begin
    if (exec) n_exec <= n_exec + 1;
    if (wr_stb) n_wr <= n_wr + 1;
    if (wr_stb) wr_last <= wr_data;
    if (!d_oe1_n) drv_seen <= drv_seen + 1;
    if (rd_req) rd_data <= memf(rd_addr, rd_otp);
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      u_host.pulse(1'b0, b[i], 1'b0, 1'b1, q1, q0);
      r[i] = q1;
    end
  endtask

  // dual: odd bit on io1, even bit on io0, msb pair first
  task automatic xd(input logic [7:0] b, input logic en, output logic [7:0] r);
    for (int i = 3; i >= 0; i--) begin
      u_host.pulse(b[2*i+1], b[2*i], en, en, q1, q0);
      r[2*i+1] = q1;
      r[2*i] = q0;
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    u_host.sel();
    xb(op, r);
    u_host.desel();
  endtask

  task automatic stat(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] r;
    u_host.sel();
    xb(op, r);
    repeat (2) begin
      xb(8'h00, r);
      chk(24'(r), 24'(exp));
    end
    u_host.desel();
  endtask

  task automatic prog(input logic [7:0] op, input int n, input logic ok);
    logic [7:0]  r, d;
    logic [23:0] a;
    logic        has_a;
    int          e0, w0;
    a = 24'($random(seed));
    has_a = !(op inside {8'hC7, 8'h60, 8'h01});
    e0 = n_exec;
    w0 = n_wr;
    u_host.sel();
    xb(op, r);
    if (has_a) for (int i = 2; i >= 0; i--) xb(a[8*i+:8], r);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (op == 8'hA2) xd(d, 1'b1, r);
      else xb(d, r);
    end
    u_host.desel();
    chk(24'(n_exec - e0), 24'(ok));
    if (ok) begin
      chk(24'(n_wr - w0), 24'(n));
      if (n > 0) chk(24'(wr_last), 24'(d));
      chk(24'(ex_op), 24'(op));
      if (has_a) chk(ex_addr, a);
      chk(24'(ex_len), 24'(n));
      chk(24'(write_enable_latch), 24'h00_0000);
    end
  endtask

  task automatic rdx(input logic [7:0] op, input int ndum, input logic dual, input logic otp);
    logic [7:0]  r;
    logic [23:0] a, e;
    logic        bb;
    // dual address and mode for BB; opcode 00 marks a continuous frame
    bb = op inside {8'hBB, 8'h00};
    a = otp ? 24'h00_003E : 24'($random(seed));
    u_host.sel();
    if (op != 8'h00) xb(op, r);
    for (int i = 2; i >= 0; i--) if (bb) xd(a[8*i+:8], 1'b1, r); else xb(a[8*i+:8], r);
    // mode byte 20h keeps the next frame continuous
    repeat (ndum) if (bb) xd(8'h20, 1'b1, r); else xb(8'h00, r);
    for (int i = 0; i < 3; i++) begin
      if (dual) xd(8'h00, 1'b0, r);
      else xb(8'h00, r);
      e = otp ? {18'h0_0000, a[5:0] + 6'(i)} : a + 24'(i);
      chk(24'(r), 24'(memf(e, otp)));
    end
    u_host.desel();
  endtask

  task automatic idrd(input logic [7:0] op, input logic [7:0] hdr, input int nh, input logic [23:0] exp);
    logic [7:0] r;
    u_host.sel();
    xb(op, r);
    for (int i = 0; i < nh; i++) xb(i == 0 ? hdr : 8'h00, r);
    for (int k = 0; k < 3; k++) begin
      xb(8'h00, r);
      // an undriven io1 shows the host's toggling, which folds to ones
      chk(24'(op == 8'hF0 ? r ^ {r[0], r[7:1]} : r), 24'(exp[23-8*k-:8]));
    end
    u_host.desel();
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    bad_count++;
    stop_test();
  end

  initial begin
    seed = 68701;
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    busy = 1'b0;
    st1 = 8'($random(seed));
    st2 = 8'($random(seed));
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(24'(write_enable_latch), 24'h00_0000);
    prog(8'h02, 2, 1'b0);
    cmd(8'h06);
    chk(24'(write_enable_latch), 24'h00_0001);
    stat(8'h05, {st1[7:2], 2'h2});
    cmd(8'h04);
    chk(24'(write_enable_latch), 24'h00_0000);
    // a frozen block misses a whole frame
    clk_en_i <= 1'b0;
    cmd(8'h06);
    clk_en_i <= 1'b1;
    chk(24'(write_enable_latch), 24'h00_0000);
    u_host.sel();
    xb(8'h06, scr);
    u_host.pulse(1'b0, 1'b0, 1'b0, 1'b1, q1, q0);
    u_host.desel();
    chk(24'(write_enable_latch), 24'h00_0000);
    busy <= 1'b1;
    st2 <= 8'($random(seed));
    cmd(8'h06);
    chk(24'(write_enable_latch), 24'h00_0000);
    stat(8'h05, {st1[7:2], 2'h1});
    stat(8'h35, st2);
    busy <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      cmd(8'h06);
      prog(ops[k], k < 5 ? 0 : k == 5 ? 2 : 1 + ($random(seed) & 3), 1'b1);
    end
    cmd(8'h06);
    prog(8'h02, 256, 1'b1);
    cmd(8'h06);
    prog(8'h02, 257, 1'b0);
    cmd(8'h06);
    prog(8'h42, 65, 1'b0);
    rdx(8'h03, 0, 1'b0, 1'b0);
    rdx(8'h0B, 1, 1'b0, 1'b0);
    rdx(8'h3B, 1, 1'b1, 1'b0);
    rdx(8'h4B, 1, 1'b0, 1'b1);
    rdx(8'h48, 1, 1'b0, 1'b1);
    rdx(8'hBB, 1, 1'b1, 1'b0);
    rdx(8'h00, 1, 1'b1, 1'b0);
    // sixteen ones on io0 end continuous mode, so an opcode is seen again
    u_host.sel();
    repeat (2) xb(8'hFF, scr);
    u_host.desel();
    stat(8'h35, st2);
    idrd(8'h9F, 8'h00, 0, {MAKER, JTYP, JCAP});
    idrd(8'h90, 8'h01, 3, {DEVID, MAKER, DEVID});
    idrd(8'h90, 8'h00, 3, {MAKER, DEVID, MAKER});
    cmd(8'h04);
    cmd(8'hB9);
    chk(24'(pd), 24'h00_0001);
    cmd(8'h06);
    chk(24'(write_enable_latch), 24'h00_0000);
    idrd(8'hAB, 8'h00, 3, {3{SIGN}});
    chk(24'(pd), 24'h00_0000);
    drv0 = drv_seen;
    idrd(8'hF0, 8'h00, 0, 24'hFF_FFFF);
    chk(24'(drv_seen - drv0), 24'h00_0000);
    stop_test();
  end
endmodule

bind sfcd_decoder sfcd_decoder_props u_props (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_io0_oe_n_o(spi_io0_oe_n_o), .spi_io1_oe_n_o(spi_io1_oe_n_o),
  .write_enable_latch_o(write_enable_latch_o), .deep_power_down_o(deep_power_down_o),
  .exec_o(exec_o), .wr_strobe_o(wr_strobe_o), .rd_req_o(rd_req_o));
